/* File: inc/aer_pkg.sv */
package aer_pkg;

    // Register byte offsets (word aligned)
    localparam logic [3:0] REG_ERROR_WORD = 4'h0;
    localparam logic [3:0] REG_CONFIG = 4'h4;
    localparam logic [3:0] REG_IRQ_STATUS = 4'h8;
    localparam logic [3:0] REG_IRQ_MASK = 4'hc;

    // Error word layout
    localparam int ERR_CLASS_LSB = 9;
    localparam int ERR_CLASS_MSB = 11;
    localparam int ERR_EXT_MSB = 8;
    localparam logic [2:0] CLASS_NONE = 3'h0;
    localparam logic [2:0] CLASS_HW = 3'h1;
    localparam logic [2:0] CLASS_CFG = 3'h2;
    localparam logic [8:0] EXT_GENERAL = 9'h000;
    localparam logic [8:0] EXT_POWERUP = 9'h001;
    localparam logic [8:0] EXT_HW_SPECIFIC = 9'h100;

    // Channel configuration: range 2 bits, filter 2 bits, format 2 bits per channel
    localparam int NUM_CH = 4;
    localparam int CFG_CH_W = 6;
    localparam int RANGE_LSB = 0;
    localparam int FILTER_LSB = 2;
    localparam int FORMAT_LSB = 4;
    localparam logic [1:0] RANGE_MAX = 2'h2;
    localparam logic [1:0] FILTER_MAX = 2'h2;
    localparam logic [1:0] FORMAT_MAX = 2'h1;
    localparam logic [23:0] CONFIG_RESET = 24'h000000;
    // Config error codes: range ch+1, filter ch+5, format ch+9
    localparam logic [8:0] EXT_RANGE_BASE = 9'h001;
    localparam logic [8:0] EXT_FILTER_BASE = 9'h005;
    localparam logic [8:0] EXT_FORMAT_BASE = 9'h009;

    // Interrupt status bits
    localparam int IRQ_HW = 0;
    localparam int IRQ_CFG = 1;
    localparam int IRQ_RANGE = 2;
    localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

    // Self test duration
    localparam int SELFTEST_NS = 1000;
    localparam int CLK_NS = 10;
    localparam int SELFTEST_CYC = (SELFTEST_NS + CLK_NS - 1) / CLK_NS;

    // Data
    localparam int DATA_W = 16;

    typedef enum logic [1:0] {ST_RESET, ST_SELFTEST, ST_RUN, ST_FAULT} aer_state_type;

endpackage

/* File: core/aer_core.sv */
// Functional notes
// - Any fault forces all analog outputs zero
// - Flag channel over/under range in input table
// - Hardware faults go to status, not data
// - Configuration faults signalled via extended field
// - Run self test sequence after power-up
// - Non-critical errors keep module running
// - Error word 16 bits, class 11:9, ext 8:0
// - Class field sits in bits 11 to 9
// - Class codes: 000 none, 001 hw, 010 config
// - No error means extended field zero
// - Hardware class carries general or specific code
// - Config class code names invalid option
// - Invalid config discarded, old config kept
// - Hex X200 is general hardware error
// - Hex X400 is general configuration error
//
// Implementation choices: the Avalon-MM interface to the registers and the register addresses.
module aer_core
    import aer_pkg::*;
(
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_resetn,
    // Avalon-MM slave
    input wire logic [3:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // Pins from analog front end
    input wire logic i_hw_fault,
    input wire logic i_selftest_fail,
    input wire logic [NUM_CH-1:0] i_over_range,
    input wire logic [NUM_CH-1:0] i_under_range,
    // Channel data
    input wire logic [NUM_CH*DATA_W-1:0] i_out_data,
    output logic [NUM_CH*DATA_W-1:0] o_analog_out,
    output logic [2*NUM_CH-1:0] o_range_flags,
    output logic [NUM_CH*CFG_CH_W-1:0] o_config,
    // Status
    output logic o_run,
    output logic o_critical,
    output logic o_irq
);

    // Pin synchronisers
    logic [1+2*NUM_CH:0] sync1_ff;
    logic [1+2*NUM_CH:0] sync2_ff;
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
        end else begin
            sync1_ff <= {i_hw_fault, i_selftest_fail, i_over_range, i_under_range};
            sync2_ff <= sync1_ff;
        end
    end
    logic hw_fault_s;
    logic st_fail_s;
    logic [NUM_CH-1:0] over_s;
    logic [NUM_CH-1:0] under_s;
    assign {hw_fault_s, st_fail_s, over_s, under_s} = sync2_ff;

    // Power-up self test sequencer
    aer_state_type state_ff;
    logic [7:0] st_cnt_ff;
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_ff <= ST_RESET;
            st_cnt_ff <= '0;
        end else begin
            case (state_ff)
                ST_RESET: begin
                    state_ff <= ST_SELFTEST;
                    st_cnt_ff <= '0;
                end
                ST_SELFTEST: begin
                    if (st_fail_s || hw_fault_s) begin
                        state_ff <= ST_FAULT;
                    end else if (st_cnt_ff == 8'(SELFTEST_CYC - 1)) begin
                        state_ff <= ST_RUN;
                    end else begin
                        st_cnt_ff <= st_cnt_ff + 8'h01;
                    end
                end
                ST_RUN: begin
                    if (hw_fault_s) begin
                        state_ff <= ST_FAULT;
                    end
                end
                default: begin
                    state_ff <= ST_FAULT; // Critical: held until reset
                end
            endcase
        end
    end

    // Write decode, error word is read only
    logic wr_cfg;
    logic wr_sts;
    logic wr_msk;
    assign wr_cfg = i_avs_write && (i_avs_address == REG_CONFIG);
    assign wr_sts = i_avs_write && (i_avs_address == REG_IRQ_STATUS);
    assign wr_msk = i_avs_write && (i_avs_address == REG_IRQ_MASK);

    // Configuration validation, a range error beats filter beats format, lowest channel wins
    logic cfg_bad;
    logic [8:0] cfg_code;
    always_comb begin
        logic [CFG_CH_W-1:0] c;
        c = '0;
        cfg_bad = 1'b0;
        cfg_code = EXT_GENERAL;
        for (int ch = NUM_CH - 1; ch >= 0; ch--) begin
            c = i_avs_writedata[ch*CFG_CH_W +: CFG_CH_W];
            if (c[FORMAT_LSB +: 2] > FORMAT_MAX) begin
                cfg_bad = 1'b1;
                cfg_code = EXT_FORMAT_BASE + 9'(ch);
            end
        end
        for (int ch = NUM_CH - 1; ch >= 0; ch--) begin
            c = i_avs_writedata[ch*CFG_CH_W +: CFG_CH_W];
            if (c[FILTER_LSB +: 2] > FILTER_MAX) begin
                cfg_bad = 1'b1;
                cfg_code = EXT_FILTER_BASE + 9'(ch);
            end
        end
        for (int ch = NUM_CH - 1; ch >= 0; ch--) begin
            c = i_avs_writedata[ch*CFG_CH_W +: CFG_CH_W];
            if (c[RANGE_LSB +: 2] > RANGE_MAX) begin
                cfg_bad = 1'b1;
                cfg_code = EXT_RANGE_BASE + 9'(ch);
            end
        end
    end

    // Accepted configuration
    logic [NUM_CH*CFG_CH_W-1:0] cfg_ff;
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            cfg_ff <= CONFIG_RESET;
        end else if (wr_cfg && !cfg_bad) begin
            cfg_ff <= i_avs_writedata[NUM_CH*CFG_CH_W-1:0];
        end
    end
    assign o_config = cfg_ff;

    // Error word: class and extended code
    logic [2:0] class_ff;
    logic [8:0] ext_ff;
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            class_ff <= CLASS_HW; // Power-up reset state
            ext_ff <= EXT_POWERUP;
        end else if (state_ff == ST_FAULT) begin
            class_ff <= CLASS_HW;
            if (hw_fault_s) begin
                ext_ff <= EXT_HW_SPECIFIC;
            end else begin
                ext_ff <= EXT_GENERAL;
            end
        end else if (state_ff == ST_RUN && wr_cfg && cfg_bad) begin
            class_ff <= CLASS_CFG;
            ext_ff <= cfg_code;
        end else if (state_ff == ST_RUN && class_ff == CLASS_HW) begin
            class_ff <= CLASS_NONE; // Self test passed
            ext_ff <= EXT_GENERAL;
        end else if (state_ff == ST_RUN && wr_cfg) begin
            class_ff <= CLASS_NONE;
            ext_ff <= EXT_GENERAL;
        end
    end
    logic [15:0] err_word;
    assign err_word = {4'h0, class_ff, ext_ff};

    // Fault flag, set in every state other than run
    logic fault;
    assign fault = (state_ff != ST_RUN);

    // Outputs forced to zero on any fault
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_analog_out <= '0;
        end else if (fault || hw_fault_s || class_ff != CLASS_NONE) begin
            o_analog_out <= '0;
        end else begin
            o_analog_out <= i_out_data;
        end
    end

    // Per-channel range flags into the input table
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_rng
            always_ff @(posedge i_mclk or negedge i_resetn) begin
                if (!i_resetn) begin
                    o_range_flags[2*g +: 2] <= 2'h0;
                end else begin
                    o_range_flags[2*g +: 2] <= {over_s[g], under_s[g]};
                end
            end
        end
    endgenerate

    // Run and critical status
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_run <= 1'b0;
            o_critical <= 1'b0;
        end else begin
            o_run <= (state_ff == ST_RUN);
            o_critical <= (state_ff == ST_FAULT);
        end
    end

    // Sticky interrupt status, write one to clear, set wins
    logic [2:0] irq_sts_ff;
    logic [2:0] irq_msk_ff;
    logic [2:0] irq_set;
    assign irq_set[IRQ_HW] = (state_ff == ST_FAULT);
    assign irq_set[IRQ_CFG] = wr_cfg && cfg_bad;
    assign irq_set[IRQ_RANGE] = |(over_s | under_s);
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            irq_sts_ff <= '0;
        end else begin
            irq_sts_ff <= irq_set | (irq_sts_ff & ~(wr_sts ? i_avs_writedata[2:0] : 3'h0));
        end
    end
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            irq_msk_ff <= IRQ_MASK_RESET;
        end else if (wr_msk) begin
            irq_msk_ff <= i_avs_writedata[2:0];
        end
    end
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(irq_sts_ff & irq_msk_ff);
        end
    end

    // Bus: one wait cycle, answer registered
    logic pend_ff;
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            pend_ff <= 1'b0;
        end else begin
            pend_ff <= (i_avs_read || i_avs_write) && !pend_ff;
        end
    end
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_avs_waitrequest <= 1'b1;
        end else begin
            o_avs_waitrequest <= !((i_avs_read || i_avs_write) && !pend_ff);
        end
    end
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_avs_readdata <= '0;
        end else if (i_avs_read && !pend_ff) begin
            if (i_avs_address == REG_ERROR_WORD) begin
                o_avs_readdata <= {16'h0000, err_word};
            end else if (i_avs_address == REG_CONFIG) begin
                o_avs_readdata <= 32'(cfg_ff);
            end else if (i_avs_address == REG_IRQ_STATUS) begin
                o_avs_readdata <= {29'h0, irq_sts_ff};
            end else if (i_avs_address == REG_IRQ_MASK) begin
                o_avs_readdata <= {29'h0, irq_msk_ff};
            end else begin
                o_avs_readdata <= '0;
            end
        end
    end

endmodule

/* File: tb/aer_core_monitor.sv */
module aer_core_monitor
    import aer_pkg::*;
(
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_resetn,
    // Bus
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic o_avs_waitrequest,
    // Pins
    input wire logic i_hw_fault,
    input wire logic [NUM_CH-1:0] i_over_range,
    input wire logic [NUM_CH-1:0] i_under_range,
    // Outputs
    input wire logic [NUM_CH*DATA_W-1:0] o_analog_out,
    input wire logic [2*NUM_CH-1:0] o_range_flags,
    input wire logic o_run,
    input wire logic o_critical,
    input wire logic o_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    int cyc_ff;
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_resetn);
    // Cycles since reset release, saturating
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn)
            cyc_ff <= 0;
        else if (cyc_ff < 1000)
            cyc_ff <= cyc_ff + 1;
    end
    AST_OUT_ZERO: assert property (o_critical |-> o_analog_out == '0)
        else $error("analog out not zero in fault");
    AST_RUN_LATE: assert property (o_run |-> cyc_ff >= SELFTEST_CYC)
        else $error("run before self test end");
    AST_RUN_DROP: assert property ($fell(o_run) |-> o_critical)
        else $error("run lost without critical fault");
    AST_CRIT_HOLD: assert property (o_critical |=> o_critical)
        else $error("critical state left without reset");
    AST_HW_CRIT: assert property (i_hw_fault [*5] |-> o_critical && !o_run)
        else $error("hardware fault not critical");
    AST_OVER_FLAG: assert property (i_over_range[0] [*5] |-> o_range_flags[1])
        else $error("over range flag missing");
    AST_UNDER_FLAG: assert property (i_under_range[3] [*5] |-> o_range_flags[6])
        else $error("under range flag missing");
    AST_WAIT_ONE: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("waitrequest low too long");
    AST_WAIT_ANS: assert property ($rose(i_avs_read) || $rose(i_avs_write)
        |-> ##[1:3] !o_avs_waitrequest)
        else $error("no bus answer");
    // Main scenarios
    cover property ($rose(o_irq));
    cover property ($rose(o_critical));
    cover property (!o_avs_waitrequest && i_avs_write);
endmodule

bind aer_core aer_core_monitor u_mon (.i_mclk, .i_resetn, .i_avs_read, .i_avs_write,
    .o_avs_waitrequest, .i_hw_fault, .i_over_range, .i_under_range, .o_analog_out,
    .o_range_flags, .o_run, .o_critical, .o_irq);

/* File: tb/aer_host_model.sv */
module aer_host_model
    import aer_pkg::*;
(
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_resetn,
    // Bus master
    output logic [3:0] o_address = 4'h0,
    output logic o_read = 1'b0,
    output logic o_write = 1'b0,
    output logic [31:0] o_writedata = 32'h0,
    input wire logic [31:0] i_readdata,
    input wire logic i_waitrequest,
    // Module status
    input wire logic i_run,
    input wire logic i_critical,
    output logic o_host_run,
    output logic o_timeout = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    logic host_run_ff;
    // Host run mode, left on critical error
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn)
            host_run_ff <= 1'b0;
        else if (i_critical)
            host_run_ff <= 1'b0;
        else if (i_run)
            host_run_ff <= 1'b1;
    end
    assign o_host_run = host_run_ff;
    // Extended field read only with a nonzero class
    function automatic logic [8:0] ext_of(input logic [31:0] w);
        return (w[11:9] != CLASS_NONE) ? w[8:0] : 9'h000;
    endfunction
    // One transfer, held until a rising edge samples waitrequest low
    task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int n;
        @(posedge i_mclk);
        o_read <= !w;
        o_write <= w;
        o_address <= a;
        o_writedata <= d;
        n = 0;
        do begin
            @(posedge i_mclk);
            n++;
        end while (i_waitrequest !== 1'b0 && n < 64);
        // Read data taken at the edge that ends the wait
        q = i_readdata;
        if (n >= 64)
            o_timeout <= 1'b1;
        o_read <= 1'b0;
        o_write <= 1'b0;
    endtask
endmodule

/* File: tb/aer_core_tb_top.sv */
module aer_core_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import aer_pkg::*;
    // Stimulus
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic hw = 1'b0;
    logic stf = 1'b0;
    logic [3:0] ovr = 4'h0;
    logic [3:0] und = 4'h0;
    logic [63:0] odata = 64'h0;
    // Bus and outputs
    logic [3:0] adr;
    logic rd_en, wr_en, waitreq, run, crit, irq, host_run, tmo;
    logic [31:0] wdata, rdata, q;
    logic [63:0] aout;
    logic [7:0] flags;
    logic [23:0] cfg;
    int miscompares = 0;
    int checks = 0;
    logic [31:0] bad [5] = '{32'h3000, 32'hc, 32'h800000, 32'h23, 32'he0};
    logic [8:0] code [5] = '{9'h3, 9'h5, 9'hc, 9'h1, 9'h2};
    always #5 mclk = ~mclk;
    aer_core dut (.i_mclk(mclk), .i_resetn(resetn), .i_avs_address(adr),
        .i_avs_read(rd_en), .i_avs_write(wr_en), .i_avs_writedata(wdata),
        .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq), .i_hw_fault(hw),
        .i_selftest_fail(stf), .i_over_range(ovr), .i_under_range(und),
        .i_out_data(odata), .o_analog_out(aout), .o_range_flags(flags),
        .o_config(cfg), .o_run(run), .o_critical(crit), .o_irq(irq));
    aer_host_model u_host (.i_mclk(mclk), .i_resetn(resetn), .o_address(adr),
        .o_read(rd_en), .o_write(wr_en), .o_writedata(wdata), .i_readdata(rdata),
        .i_waitrequest(waitreq), .i_run(run), .i_critical(crit),
        .o_host_run(host_run), .o_timeout(tmo));
    // Compare and bus helpers
    task chk(input logic [95:0] got, input logic [95:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task rd(input logic [3:0] a, input logic [31:0] e);
        u_host.xfer(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask
    task wr(input logic [3:0] a, input logic [31:0] d);
        u_host.xfer(1'b1, a, d, q);
    endtask
    task cyc(input int n);
        repeat (n) @(posedge mclk);
        @(negedge mclk);
    endtask
    task test_done;
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Bus hang cut short
    always @(posedge tmo) begin
        miscompares++;
        test_done();
    end
    // Main sequence
    initial begin
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        rd(REG_ERROR_WORD, 32'h201);
        cyc(0);
        chk(aout, 64'h0);
        for (int n = 0; n < 300 && run !== 1'b1; n++)
            cyc(0);
        chk(run, 1'b1);
        rd(REG_ERROR_WORD, 32'h0);
        wr(REG_ERROR_WORD, 32'hffff);
        rd(REG_ERROR_WORD, 32'h0);
        rd(4'h2, 32'h0);
        rd(REG_IRQ_MASK, 32'h0);
        wr(REG_IRQ_STATUS, 32'h7);
        odata <= 64'h1234_5678_9abc_def0;
        ovr <= 4'h1;
        und <= 4'h8;
        cyc(6);
        chk({flags, run, host_run, irq}, {8'h42, 3'h6});
        rd(REG_ERROR_WORD, 32'h0);
        rd(REG_IRQ_STATUS, 32'h4);
        wr(REG_IRQ_MASK, 32'h7);
        cyc(2);
        chk(irq, 1'b1);
        @(posedge mclk);
        ovr <= 4'h0;
        und <= 4'h0;
        wr(REG_IRQ_STATUS, 32'h4);
        cyc(2);
        chk({flags, irq}, 9'h0);
        wr(REG_CONFIG, 32'h4001a);
        rd(REG_CONFIG, 32'h4001a);
        for (int i = 0; i < 5; i++) begin
            wr(REG_CONFIG, bad[i]);
            rd(REG_ERROR_WORD, {23'h2, code[i]});
            chk(u_host.ext_of(q), code[i]);
            cyc(2);
            chk({cfg, run, aout}, {24'h4001a, 1'b1, 64'h0});
        end
        rd(REG_IRQ_STATUS, 32'h2);
        wr(REG_CONFIG, 32'h0);
        rd(REG_ERROR_WORD, 32'h0);
        cyc(3);
        chk(aout, odata);
        @(posedge mclk);
        hw <= 1'b1;
        cyc(6);
        chk({crit, run, host_run, aout}, {3'h4, 64'h0});
        rd(REG_ERROR_WORD, 32'h300);
        hw <= 1'b0;
        resetn <= 1'b0;
        stf <= 1'b1;
        cyc(2);
        @(posedge mclk);
        resetn <= 1'b1;
        cyc(130);
        chk({crit, run}, 2'h2);
        rd(REG_ERROR_WORD, 32'h200);
        test_done();
    end
endmodule
